// file: verilog/alm_cfg.svh
// Purpose: constants of the async line control block
// Assumes: included by its bare name
// Notes: bit positions refer to the line control register
`ifndef ALM_CFG_SVH
`define ALM_CFG_SVH
// ----------------------------------------
// register slots (pointer bits 4:3)
// ----------------------------------------
`define ALM_OFS_ZERO 5'h00
`define ALM_OFS_EIGHT 5'h08
// ----------------------------------------
// line control fields
// ----------------------------------------
`define ALM_B_PREEMPT 15
`define ALM_B_RTS 12
`define ALM_B_DTR 9
`define ALM_B_USER 8
`define ALM_B_MODE_HI 7
`define ALM_B_MODE_LO 6
`define ALM_B_WATCH 5
`define ALM_B_FLUSH 4
`define ALM_B_BREAK 3
`define ALM_B_RXON 2
`define ALM_B_FLOW 1
`define ALM_B_TXON 0
`define ALM_CTRL_MASK 16'h93FF
`define ALM_CTRL_RST 16'h0000
// ----------------------------------------
// silo, flow characters, timing
// ----------------------------------------
`define ALM_SILO_DEPTH 32
`define ALM_XON 8'h11
`define ALM_XOFF 8'h13
`define ALM_CLK_HZ 10000000
`define ALM_BAUD 9600
`define ALM_BAUD_DIV (`ALM_CLK_HZ / `ALM_BAUD)
`define ALM_FRAME_BITS 10
`endif

// file: verilog/alm_pkg.sv
// Purpose: types of the async line control block
// Assumes: alm_cfg.svh supplies the sizes
// Notes: whole module state lives in alm_state_t
`include "alm_cfg.svh"
package alm_pkg;
	typedef enum logic [1:0] {ALM_NORMAL, ALM_ECHO, ALM_LOCAL, ALM_REMOTE} alm_mode_t;
	typedef enum logic {ALM_TX_IDLE, ALM_TX_SHIFT} alm_txst_t;
	typedef struct packed {
		logic dsr;
		logic ring;
		logic carrier;
		logic cts;
		logic sec_carrier;
	} alm_modem_t;
	typedef struct packed {
		alm_modem_t sync1;
		alm_modem_t sync2;
		alm_modem_t shown;
		logic chg_pend;
		logic [15:0] ctrl;
		logic rts_o;
		logic dtr_o;
		logic user_o;
		logic [`ALM_SILO_DEPTH-1:0][7:0] silo;
		logic [4:0] rd_ptr;
		logic [4:0] wr_ptr;
		logic [5:0] count;
		logic [7:0] pre_char;
		logic pre_pend;
		logic [7:0] echo_char;
		logic echo_pend;
		logic xoff;
		alm_txst_t txst;
		logic [9:0] shreg;
		logic [3:0] bitn;
		logic [15:0] divc;
		logic tick;
		logic txd;
		logic loop_rx;
		logic [15:0] rdata;
		logic rvalid;
		logic tx_rdy;
		logic [2:0] tx_line;
		logic chg_req;
		logic dma_stop;
		logic rx_store_en;
	} alm_state_t;
endpackage : alm_pkg

// file: verilog/alm_line_ctrl.sv
// Purpose: control and status logic of one asynchronous multiplexer line
// Assumes: inputs synchronous to sys_clk except the modem lines
// Notes: srst is bus init, master_rst is the master reset pulse
`timescale 1ns/100ps
`default_nettype none
`include "alm_cfg.svh"
module alm_line_ctrl
	import alm_pkg::*;
#(
	parameter logic [2:0] LINE_NUM = 3'h0,
	parameter logic [15:0] BAUD_DIV = 16'(`ALM_BAUD_DIV)
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic master_rst,
	input wire logic [4:0] ptr,
	input wire logic rd_stb,
	input wire logic wr_stb,
	input wire logic wr_byte,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata,
	output logic rvalid,
	input wire logic dsr_in,
	input wire logic dsr_enable,
	input wire logic ring_indicator_in,
	input wire logic carrier_detect_in,
	input wire logic cts_in,
	input wire logic secondary_carrier_in,
	input wire logic rxd_in,
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char,
	input wire logic rx_silo_room,
	output logic txd,
	output logic rts_out,
	output logic dtr_out,
	output logic user_out,
	output logic rx_serial,
	output logic rx_store_en,
	output logic modem_change_flag,
	output logic tx_ready,
	output logic [2:0] tx_line,
	output logic dma_stop
);
	// ----------------------------------------
	// state and helpers
	// ----------------------------------------
	alm_state_t s_q, s_d;
	alm_modem_t eff;
	alm_mode_t mode;
	logic wr0, wr8, sel, tx_ok, echo_on;
	logic [5:0] cnt;
	logic [4:0] wp, rp;

	// slot match: line in low bits, register in upper bits
	function automatic logic slot_hit(input logic [4:0] p, input logic [4:0] ofs);
		slot_hit = (p[4:3] == ofs[4:3]);
	endfunction : slot_hit

	assign sel = (ptr[2:0] == LINE_NUM);
	assign wr0 = wr_stb && sel && slot_hit(ptr, `ALM_OFS_ZERO);
	assign wr8 = wr_stb && sel && slot_hit(ptr, `ALM_OFS_EIGHT);
	assign mode = alm_mode_t'(s_q.ctrl[`ALM_B_MODE_HI:`ALM_B_MODE_LO]);
	assign echo_on = (mode == ALM_ECHO && s_q.ctrl[`ALM_B_RXON]) || mode == ALM_REMOTE;
	// transmit enable, flow stop, preempt, break and cts all gate silo output
	assign tx_ok = s_q.ctrl[`ALM_B_TXON] && !s_q.xoff && !s_q.ctrl[`ALM_B_PREEMPT]
		&& !s_q.ctrl[`ALM_B_BREAK] && eff.cts && mode != ALM_REMOTE;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		cnt = s_q.count;
		wp = s_q.wr_ptr;
		rp = s_q.rd_ptr;
		eff = s_q.sync2;
		s_d.tick = 1'b0;
		s_d.rvalid = 1'b0;
		s_d.tx_rdy = 1'b0;
		s_d.chg_req = 1'b0;
		s_d.dma_stop = 1'b0;
		// first stage feeds only the second
		s_d.sync1 = '{dsr_in, ring_indicator_in, carrier_detect_in, cts_in,
			secondary_carrier_in};
		s_d.sync2 = s_q.sync1;
		// local loopback: carrier follows dtr bit, cts follows rts bit
		if (mode == ALM_LOCAL) begin
			eff.carrier = s_q.ctrl[`ALM_B_DTR];
			eff.cts = s_q.ctrl[`ALM_B_RTS];
		end
		// status byte holds only while a change is pending and the silo has no room
		if (eff != s_q.shown && (!s_q.chg_pend || rx_silo_room)) begin
			s_d.shown = eff;
			s_d.chg_req = s_q.ctrl[`ALM_B_WATCH];
		end
		s_d.chg_pend = s_q.ctrl[`ALM_B_WATCH] && eff != s_q.shown && !rx_silo_room;
		// bit-rate divider
		if (s_q.divc >= BAUD_DIV - 16'h0001) begin
			s_d.divc = 16'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.divc = s_q.divc + 16'h0001;
		end
		// flush keeps the character in the serializer
		if (s_q.ctrl[`ALM_B_FLUSH]) begin
			cnt = 6'h00;
			rp = wp;
			s_d.ctrl[`ALM_B_FLUSH] = 1'b0;
			s_d.tx_rdy = 1'b1;
			s_d.tx_line = LINE_NUM;
			s_d.dma_stop = 1'b1;
		end
		// serializer: start only when idle, so a character is never cut
		if (s_q.txst == ALM_TX_IDLE) begin
			if (echo_on && s_q.echo_pend) begin
				s_d.shreg = {1'b1, s_q.echo_char, 1'b0};
				s_d.echo_pend = 1'b0;
				s_d.txst = ALM_TX_SHIFT;
				s_d.bitn = 4'h0;
			end else if (s_q.pre_pend && !s_q.ctrl[`ALM_B_BREAK]) begin
				s_d.shreg = {1'b1, s_q.pre_char, 1'b0};
				s_d.pre_pend = 1'b0;
				s_d.txst = ALM_TX_SHIFT;
				s_d.bitn = 4'h0;
			end else if (tx_ok && cnt != 6'h00) begin
				s_d.shreg = {1'b1, s_q.silo[rp], 1'b0};
				rp = rp + 5'h01;
				cnt = cnt - 6'h01;
				s_d.txst = ALM_TX_SHIFT;
				s_d.bitn = 4'h0;
			end
		end else if (s_q.tick) begin
			s_d.shreg = {1'b1, s_q.shreg[9:1]};
			s_d.bitn = s_q.bitn + 4'h1;
			if (s_q.bitn == 4'(`ALM_FRAME_BITS - 1)) begin
				s_d.txst = ALM_TX_IDLE;
			end
		end
		// transmit character load; dma-mode writes are the writer's fault
		if (wr0) begin
			if (s_q.ctrl[`ALM_B_PREEMPT]) begin
				s_d.pre_char = wdata[7:0];
				s_d.pre_pend = 1'b1;
				s_d.ctrl[`ALM_B_PREEMPT] = 1'b0;
			end else begin
				if (cnt < 6'(`ALM_SILO_DEPTH)) begin
					s_d.silo[wp] = wdata[7:0];
					wp = wp + 5'h01;
					cnt = cnt + 6'h01;
				end
				if (!wr_byte && cnt < 6'(`ALM_SILO_DEPTH)) begin
					s_d.silo[wp] = wdata[15:8];
					wp = wp + 5'h01;
					cnt = cnt + 6'h01;
				end
			end
		end
		// control load also refreshes the physical modem lines
		if (wr8) begin
			s_d.ctrl = wdata & `ALM_CTRL_MASK;
			s_d.rts_o = wdata[`ALM_B_RTS];
			s_d.dtr_o = wdata[`ALM_B_DTR];
			s_d.user_o = wdata[`ALM_B_USER];
		end
		// received characters: flow control and echo capture
		if (rx_char_valid && s_q.ctrl[`ALM_B_RXON] && s_q.ctrl[`ALM_B_FLOW]) begin
			if (rx_char == `ALM_XOFF) begin
				s_d.xoff = 1'b1;
			end else if (rx_char == `ALM_XON) begin
				s_d.xoff = 1'b0;
			end
		end
		if (rx_char_valid && echo_on) begin
			s_d.echo_char = rx_char;
			s_d.echo_pend = 1'b1;
		end
		// register reads answer one cycle later
		if (rd_stb && sel) begin
			s_d.rvalid = 1'b1;
			if (slot_hit(ptr, `ALM_OFS_ZERO)) begin
				s_d.rdata = {s_q.shown.dsr & dsr_enable, s_q.shown.ring, s_q.shown.carrier,
					s_q.shown.cts, s_q.shown.sec_carrier, 3'h0, 2'h0, s_q.count};
			end else if (slot_hit(ptr, `ALM_OFS_EIGHT)) begin
				s_d.rdata = s_q.ctrl;
			end else begin
				s_d.rdata = 16'h0000;
			end
		end
		// line side: local mode holds the line marking, break holds it spacing while the serializer is idle
		if (s_q.txst == ALM_TX_SHIFT) begin
			s_d.txd = (mode == ALM_LOCAL) ? 1'b1 : s_q.shreg[0];
			s_d.loop_rx = (mode == ALM_LOCAL) ? s_q.shreg[0] : rxd_in;
		end else begin
			s_d.txd = (mode == ALM_LOCAL) || !s_q.ctrl[`ALM_B_BREAK];
			s_d.loop_rx = (mode == ALM_LOCAL) ? 1'b1 : rxd_in;
		end
		s_d.rx_store_en = s_q.ctrl[`ALM_B_RXON] && mode != ALM_REMOTE;
		s_d.count = cnt;
		s_d.wr_ptr = wp;
		s_d.rd_ptr = rp;
		// master reset clears register bits but not the driven modem lines
		if (master_rst) begin
			s_d.ctrl = `ALM_CTRL_RST;
			s_d.count = 6'h00;
			s_d.rd_ptr = 5'h00;
			s_d.wr_ptr = 5'h00;
			s_d.shown = '0;
			s_d.pre_pend = 1'b0;
			s_d.xoff = 1'b0;
		end
	end

	// ----------------------------------------
	// state register; init clears everything including modem lines, except txd and loop_rx, which it sets marking
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.txd <= 1'b1;
			s_q.loop_rx <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign rvalid = s_q.rvalid;
	assign txd = s_q.txd;
	assign rts_out = s_q.rts_o;
	assign dtr_out = s_q.dtr_o;
	assign user_out = s_q.user_o;
	assign rx_serial = s_q.loop_rx;
	assign rx_store_en = s_q.rx_store_en;
	assign modem_change_flag = s_q.chg_req;
	assign tx_ready = s_q.tx_rdy;
	assign tx_line = s_q.tx_line;
	assign dma_stop = s_q.dma_stop;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	chk_read_count: assert property (
		rd_stb && sel && slot_hit(ptr, `ALM_OFS_ZERO) |=> rdata[7:0] == 8'($past(s_q.count)))
		else $error("status read does not show silo count");
	chk_mreset_count: assert property (
		master_rst |=> s_q.count == 6'h00 && s_q.ctrl == `ALM_CTRL_RST)
		else $error("master reset left count or control set");
	chk_word_order: assert property (
		wr0 && !wr_byte && !s_q.ctrl[`ALM_B_PREEMPT] && !s_q.ctrl[`ALM_B_FLUSH]
		&& s_q.count < 6'h1E && !master_rst |=> s_q.silo[$past(s_q.wr_ptr)] == $past(wdata[7:0])
		&& s_q.silo[5'($past(s_q.wr_ptr) + 5'h01)] == $past(wdata[15:8])
		&& s_q.wr_ptr == 5'($past(s_q.wr_ptr) + 5'h02))
		else $error("word write did not push low then high byte");
	chk_byte_push: assert property (
		wr0 && wr_byte && !s_q.ctrl[`ALM_B_PREEMPT] && s_q.count < 6'h1F && !master_rst
		|=> s_q.wr_ptr == 5'($past(s_q.wr_ptr) + 5'h01))
		else $error("byte write pushed wrong number of bytes");
	chk_preempt_load: assert property (
		wr0 && s_q.ctrl[`ALM_B_PREEMPT] && !wr8 && !master_rst
		|=> !s_q.ctrl[`ALM_B_PREEMPT] && s_q.pre_pend
		&& s_q.wr_ptr == $past(s_q.wr_ptr))
		else $error("preempt load mishandled");
	chk_preempt_halt: assert property (
		s_q.ctrl[`ALM_B_PREEMPT] && !s_q.pre_pend && !s_q.echo_pend && s_q.txst == ALM_TX_IDLE
		|=> s_q.txst == ALM_TX_IDLE)
		else $error("silo sent while preempt set");
	chk_modem_lines: assert property (
		wr8 && !master_rst |=> rts_out == $past(wdata[`ALM_B_RTS])
		&& dtr_out == $past(wdata[`ALM_B_DTR]) && user_out == $past(wdata[`ALM_B_USER]))
		else $error("modem outputs do not follow control load");
	chk_mreset_keep: assert property (
		master_rst && !wr8 |=> $stable(rts_out) && $stable(dtr_out) && $stable(user_out))
		else $error("master reset changed modem outputs");
	chk_flush_done: assert property (
		s_q.ctrl[`ALM_B_FLUSH] && !wr8 && !master_rst |=> !s_q.ctrl[`ALM_B_FLUSH]
		&& tx_ready && tx_line == LINE_NUM && dma_stop)
		else $error("flush did not complete");
	chk_local_mark: assert property (
		mode == ALM_LOCAL && $past(mode == ALM_LOCAL) |-> txd)
		else $error("line not marking in local loopback");
	chk_remote_store: assert property (
		mode == ALM_REMOTE ##1 mode == ALM_REMOTE |-> !rx_store_en)
		else $error("remote loopback stores received data");
	cov_flush: cover property (s_q.ctrl[`ALM_B_FLUSH] ##1 tx_ready);
	cov_preempt: cover property (wr0 && s_q.ctrl[`ALM_B_PREEMPT] ##[1:20] s_q.txst == ALM_TX_SHIFT);
	cov_change: cover property (modem_change_flag);
endmodule : alm_line_ctrl
`default_nettype wire

// file: bench/alm_modem_model.sv
// Purpose: behavioural modem on the far side of one async line
// Assumes: bench chooses the line levels; cts answers rts after CTS_DLY clocks
// Notes: lines change off the clock edge to exercise the synchroniser
`timescale 1ns/100ps
`default_nettype none
module alm_modem_model #(
	parameter int CTS_DLY = 3
) (
	input wire logic sys_clk,
	input wire logic rts_out,
	input wire logic [4:0] lines_set,
	output logic dsr_in,
	output logic ring_indicator_in,
	output logic carrier_detect_in,
	output logic cts_in,
	output logic secondary_carrier_in,
	output logic rxd_in
);
	logic [7:0] rts_hist_q = 8'h00;
	// -----------------------------------------
	// modem answers
	// -----------------------------------------
	// a slow modem: clear to send lags request to send
	always @(posedge sys_clk) rts_hist_q <= {rts_hist_q[6:0], rts_out};
	assign #37 {dsr_in, ring_indicator_in, carrier_detect_in} = lines_set[4:2];
	assign #37 cts_in = lines_set[1] & rts_hist_q[CTS_DLY-1];
	assign #37 secondary_carrier_in = lines_set[0];
	// no received traffic: data line idles marking
	assign rxd_in = 1'b1;
endmodule : alm_modem_model
`default_nettype wire

// file: bench/tb.sv
// Purpose: self-checking bench of the async line control block
// Assumes: BAUD_DIV of 4, line number 0, receive path idle
// Notes: model keeps ctrl value and silo occupancy as integers
`timescale 1ns/100ps
`default_nettype none
module tb;
	import alm_pkg::*;
	logic sys_clk = 1'b0, srst = 1'b1, master_rst = 1'b0, rd_stb = 1'b0, wr_stb = 1'b0;
	logic wr_byte = 1'b0, dsr_enable = 1'b1;
	logic [4:0] ptr = 5'h00, lines = 5'h00;
	logic [15:0] wdata = 16'h0000, rdata, r, v;
	logic rvalid, dsr_in, ring_in, car_in, cts_in, sec_in, rxd_in, txd, rts_out, dtr_out;
	logic user_out, chg, tx_ready, dma_stop;
	logic [2:0] tx_line;
	logic [7:0] c, g, p;
	int fails = 0, num_checks = 0, m_count = 0, chg_seen = 0, i, k, seed;
	logic [15:0] m_ctrl = 16'h0000;
	// -----------------------------------------
	// clock, design, partner
	// -----------------------------------------
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (chg === 1'b1) chg_seen++;
	alm_line_ctrl #(.BAUD_DIV(16'h0004)) u_alm_line_ctrl (.sys_clk(sys_clk), .srst(srst),
		.master_rst(master_rst), .ptr(ptr), .rd_stb(rd_stb), .wr_stb(wr_stb),
		.wr_byte(wr_byte), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .dsr_in(dsr_in),
		.dsr_enable(dsr_enable), .ring_indicator_in(ring_in), .carrier_detect_in(car_in),
		.cts_in(cts_in), .secondary_carrier_in(sec_in), .rxd_in(rxd_in),
		.rx_char_valid(1'b0), .rx_char(8'h00), .rx_silo_room(1'b1), .txd(txd),
		.rts_out(rts_out), .dtr_out(dtr_out), .user_out(user_out), .rx_serial(),
		.rx_store_en(), .modem_change_flag(chg), .tx_ready(tx_ready), .tx_line(tx_line),
		.dma_stop(dma_stop));
	alm_modem_model u_alm_modem_model (.sys_clk(sys_clk), .rts_out(rts_out),
		.lines_set(lines), .dsr_in(dsr_in), .ring_indicator_in(ring_in),
		.carrier_detect_in(car_in), .cts_in(cts_in), .secondary_carrier_in(sec_in),
		.rxd_in(rxd_in));
	// -----------------------------------------
	// checking and bus tasks
	// -----------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask : tick
	task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic b);
		ptr = a;
		wdata = d;
		wr_byte = b;
		wr_stb = 1'b1;
		tick(1);
		wr_stb = 1'b0;
	endtask : wr
	// read answer comes within a few clocks; a missing answer is a mismatch
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		ptr = a;
		rd_stb = 1'b1;
		tick(1);
		rd_stb = 1'b0;
		for (int n = 0; n < 3 && rvalid !== 1'b1; n++) tick(1);
		chk("rvalid", 16'h0001, {15'h0000, rvalid});
		d = rdata;
		tick(1);
	endtask : rd
	// silo pushes beyond the depth are dropped
	task automatic push(input int n);
		m_count = (m_count + n > 32) ? 32 : m_count + n;
	endtask : push
	task automatic status_chk();
		rd(5'h00, r);
		chk("status", {dsr_enable & lines[4], lines[3:2], lines[1] & m_ctrl[12], lines[0],
			3'h0, 8'(m_count)}, r);
	endtask : status_chk
	task automatic wctl(input logic [15:0] d);
		wr(5'h08, d, 1'b0);
		m_ctrl = d & 16'h93FF;
		rd(5'h08, r);
		chk("ctrl", m_ctrl, r);
		chk("modem_out", {13'h0000, m_ctrl[12], m_ctrl[9], m_ctrl[8]},
			{13'h0000, rts_out, dtr_out, user_out});
	endtask : wctl
	// frame capture; the character's bit 0 must be one so a short start bit is harmless
	task automatic get_frame(output logic [7:0] ch);
		for (int n = 0; n < 400 && txd !== 1'b0; n++) tick(1);
		for (int n = 0; n < 6 && txd !== 1'b1; n++) tick(1);
		tick(2);
		for (int b = 0; b < 8; b++) begin
			ch[b] = txd;
			tick(4);
		end
		chk("stop_bit", 16'h0001, {15'h0000, txd});
	endtask : get_frame
	// -----------------------------------------
	// watchdog
	// -----------------------------------------
	initial begin
		#(100 * 30000);
		fails++;
		end_sim();
	end
	// -----------------------------------------
	// scenarios
	// -----------------------------------------
	initial begin
		seed = 32'haff1;
		tick(8);
		srst = 1'b0;
		status_chk();
		rd(5'h08, r);
		chk("ctrl_reset", 16'h0000, r);
		rd(5'h10, r);
		chk("unmapped", 16'h0000, r);
		for (i = 0; i < 4; i++) wctl(16'($random(seed)) & 16'h132E);
		wr(5'h0B, 16'hFFFF, 1'b0);
		rd(5'h08, r);
		chk("other_line", m_ctrl, r);
		// fill the silo past full with the transmitter off
		for (i = 0; i < 17; i++) begin
			wr(5'h00, 16'($random(seed)), 1'b0);
			push(2);
			if (i % 5 == 0) status_chk();
		end
		wr(5'h00, 16'h0055, 1'b1);
		status_chk();
		// flush
		wr(5'h08, 16'h0010, 1'b0);
		for (k = 0; k < 4 && tx_ready !== 1'b1; k++) tick(1);
		chk("flush_end", 16'h0011, {11'h000, tx_ready, 3'h0, dma_stop});
		chk("tx_line", 16'h0000, {13'h0000, tx_line});
		m_ctrl = 16'h0000;
		m_count = 0;
		status_chk();
		rd(5'h08, r);
		chk("flush_bit", 16'h0000, r);
		for (i = 0; i < 3; i++) wr(5'h00, 16'hAB00 | 16'(i), 1'b1);
		push(3);
		status_chk();
		// master reset keeps modem outputs, init clears them
		wctl(16'h1300);
		master_rst = 1'b1;
		tick(1);
		master_rst = 1'b0;
		m_ctrl = 16'h0000;
		m_count = 0;
		status_chk();
		rd(5'h08, r);
		chk("ctrl_mrst", 16'h0000, r);
		chk("out_mrst", 16'h0007, {13'h0000, rts_out, dtr_out, user_out});
		srst = 1'b1;
		tick(1);
		srst = 1'b0;
		chk("out_init", 16'h0000, {13'h0000, rts_out, dtr_out, user_out});
		// modem status and change detection
		wctl(16'h1020);
		for (i = 0; i < 8; i++) begin
			v = {11'h000, lines};
			chg_seen = 0;
			lines = 5'($random(seed));
			tick(8);
			status_chk();
			chk("change", {15'h0000, v[4:0] != lines}, {15'h0000, chg_seen != 0});
		end
		dsr_enable = 1'b0;
		lines = 5'h12;
		tick(8);
		status_chk();
		wctl(16'h1000);
		chg_seen = 0;
		lines = 5'h0E;
		tick(8);
		chk("no_watch", 16'h0000, 16'(chg_seen));
		// transmit: byte, word order, preempt insertion
		dsr_enable = 1'b1;
		lines = 5'h02;
		wctl(16'h1001);
		c = 8'($random(seed)) | 8'h01;
		wr(5'h00, {8'hFF, c}, 1'b1);
		get_frame(g);
		chk("byte_char", {8'h00, c}, {8'h00, g});
		v = 16'($random(seed)) | 16'h0101;
		wr(5'h00, v, 1'b0);
		get_frame(g);
		chk("word_low", {8'h00, v[7:0]}, {8'h00, g});
		get_frame(g);
		chk("word_high", {8'h00, v[15:8]}, {8'h00, g});
		tick(40);
		wctl(16'h1000);
		wr(5'h00, 16'h0033, 1'b1);
		wctl(16'h9001);
		p = 8'h11;
		wr(5'h00, {8'h00, p}, 1'b1);
		rd(5'h08, r);
		chk("preempt_clr", 16'h1001, r);
		get_frame(g);
		chk("preempt_char", {8'h00, p}, {8'h00, g});
		get_frame(g);
		chk("silo_after", 16'h0033, {8'h00, g});
		// local loopback: line held marking, carrier and cts follow dtr and rts bits
		wctl(16'h1381);
		wr(5'h00, 16'h0055, 1'b1);
		k = 0;
		for (i = 0; i < 60; i++) begin
			tick(1);
			if (txd !== 1'b1) k++;
		end
		chk("local_mark", 16'h0000, 16'(k));
		rd(5'h00, r);
		chk("local_status", 16'h3000, r & 16'h3000);
		end_sim();
	end
endmodule : tb
`default_nettype wire
